// file: pkg/prog_port_pkg.sv
// package for the muxed-address programming port host controller
// assumes a 250 MHz system clock; all pin timings are expressed in cycles of it
package prog_port_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 4000;
    localparam int RST_LOW_NS        = 100;   // least reset low time
    localparam int RST_RECOVER_NS    = 1000;  // least reset-high to first address/strobe
    localparam int WE_LOW_NS         = 100;   // least write strobe low phase
    localparam int WE_HIGH_NS        = 100;   // least write strobe high phase
    localparam int WRITE_RECOVER_NS  = 150;   // write recovery before read
    localparam int ADDR_SETUP_NS     = 50;    // address setup and hold to row/column strobe
    localparam int DATA_SETUP_NS     = 50;    // data setup to write strobe high
    localparam int DATA_HOLD_NS      = 5;     // data hold after write strobe high
    localparam int READ_ACCESS_NS    = 150;   // row/column high to data valid

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int RST_LOW_CYC       = ns_to_cyc(RST_LOW_NS);
    localparam int RST_RECOVER_CYC   = ns_to_cyc(RST_RECOVER_NS);
    localparam int WE_LOW_CYC        = ns_to_cyc(WE_LOW_NS);
    localparam int WE_HIGH_CYC       = ns_to_cyc(WE_HIGH_NS);
    localparam int WRITE_RECOVER_CYC = ns_to_cyc(WRITE_RECOVER_NS);
    localparam int ADDR_SETUP_CYC    = ns_to_cyc(ADDR_SETUP_NS);
    localparam int DATA_SETUP_CYC    = ns_to_cyc(DATA_SETUP_NS);
    localparam int DATA_HOLD_CYC     = ns_to_cyc(DATA_HOLD_NS);
    localparam int READ_ACCESS_CYC   = ns_to_cyc(READ_ACCESS_NS);

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int ROW_W  = 11;
    localparam int COL_W  = 9;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 9;
    localparam logic [ROW_W-1:0] ROW_RST = 11'h000;

    // command request from the user side
    typedef struct packed {
        logic              write;  // 1 = command write, 0 = read
        logic [ROW_W-1:0]  row;
        logic [COL_W-1:0]  col;
        logic [DATA_W-1:0] data;
    } req_t;

    typedef enum logic [3:0] {
        ST_RESET, ST_RECOVER, ST_IDLE, ST_ROW, ST_ROW_HOLD, ST_COL, ST_COL_HOLD,
        ST_WE_LOW, ST_WE_HOLD, ST_WE_HIGH, ST_RD_WAIT, ST_RD_DATA
    } state_t;

endpackage : prog_port_pkg

// file: hdl/prog_port_host.sv
// host controller that drives the muxed-address programming port of a flash part
// assumes pins are driven directly; the data bus is split into in/out/enable signals
`timescale 1ns/10ps

// Operation
// - command write only with write strobe low and output enable high
// - host holds reset low at least 100 ns
// - host waits recovery after later of ready/busy or reset rising
// - host waits 1 us after reset release before first row address
// - host waits 1 us after reset release before write strobe low
// - write strobe low and high phases each at least 100 ns
// - host allows 150 ns write recovery before asserting output enable
module prog_port_host
    import prog_port_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // user request side
    input  wire logic              start,
    input  wire req_t              req,
    input  wire logic              reset_req,
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   dev_ready,
    // device pins
    output logic                   reset_power_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic                   row_col,
    output logic [ROW_W-1:0]       addr,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic              ready_busy_n
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] dq_meta_reg, dq_sync_reg;
    logic              rb_meta_reg, rb_sync_reg;

    // two flops on every device-driven pin before any logic looks at it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
            rb_meta_reg <= 1'b0;
            rb_sync_reg <= 1'b0;
        end else begin
            dq_meta_reg <= dq_in;
            dq_sync_reg <= dq_meta_reg;
            rb_meta_reg <= ready_busy_n;
            rb_sync_reg <= rb_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    state_t           state_reg;
    logic [CNT_W-1:0] cnt_reg;
    req_t             req_reg;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction : cyc

    wire cnt_zero = (cnt_reg == '0);

    // state, timer and latched request; every phase waits out its own least time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_RESET;
            cnt_reg     <= cyc(RST_LOW_CYC);
            req_reg     <= '0;
        end else begin
            if (!cnt_zero)
                cnt_reg <= cnt_reg - 1'b1;
            unique case (state_reg)
                ST_RESET: begin
                    if (cnt_zero) begin
                        state_reg   <= ST_RECOVER;
                        cnt_reg     <= cyc(RST_RECOVER_CYC);
                    end
                end
                ST_RECOVER: begin
                    // timer restarts until ready/busy is high: count from the later edge
                    if (!rb_sync_reg)
                        cnt_reg <= cyc(RST_RECOVER_CYC);
                    else if (cnt_zero)
                        state_reg <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (reset_req) begin
                        state_reg <= ST_RESET;
                        cnt_reg   <= cyc(RST_LOW_CYC);
                    end else if (start) begin
                        req_reg   <= req;
                        state_reg <= ST_ROW;
                        cnt_reg   <= cyc(ADDR_SETUP_CYC);
                    end
                end
                ST_ROW: if (cnt_zero) begin
                    state_reg <= ST_ROW_HOLD;
                    // addr switches a register stage ahead of row_col, so row hold needs one more cycle
                    cnt_reg   <= cyc(ADDR_SETUP_CYC + 1);
                end
                ST_ROW_HOLD: if (cnt_zero) begin
                    state_reg <= ST_COL;
                    cnt_reg   <= cyc(ADDR_SETUP_CYC);
                end
                ST_COL: if (cnt_zero) begin
                    state_reg <= ST_COL_HOLD;
                    cnt_reg   <= cyc(ADDR_SETUP_CYC);
                end
                ST_COL_HOLD: if (cnt_zero) begin
                    state_reg <= req_reg.write ? ST_WE_LOW : ST_RD_WAIT;
                    cnt_reg   <= req_reg.write ? cyc(WE_LOW_CYC > DATA_SETUP_CYC ? WE_LOW_CYC : DATA_SETUP_CYC)
                                               : cyc(READ_ACCESS_CYC);
                end
                ST_WE_LOW: if (cnt_zero) begin
                    state_reg <= ST_WE_HOLD;
                    cnt_reg   <= cyc(DATA_HOLD_CYC);
                end
                ST_WE_HOLD: if (cnt_zero) begin
                    state_reg <= ST_WE_HIGH;
                    cnt_reg   <= cyc(WRITE_RECOVER_CYC);
                end
                ST_WE_HIGH: if (cnt_zero)
                    state_reg <= ST_IDLE;
                ST_RD_WAIT: if (cnt_zero)
                    state_reg <= ST_RD_DATA;
                ST_RD_DATA:
                    state_reg <= ST_IDLE;
                default: state_reg <= ST_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin drivers, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reset_power_n <= 1'b0;
            oe_n          <= 1'b1;
            we_n          <= 1'b1;
            row_col       <= 1'b1;
            addr          <= ROW_RST;
            dq_out        <= '0;
            dq_oe         <= 1'b0;
        end else begin
            reset_power_n <= !(state_reg == ST_RESET);
            // address pins carry row first, column (zero extended) after row falls
            if (state_reg == ST_ROW || state_reg == ST_IDLE)
                addr <= (state_reg == ST_IDLE && start) ? req.row : addr;
            if (state_reg == ST_ROW_HOLD && cnt_zero)
                addr <= ROW_W'(req_reg.col);
            row_col <= !(state_reg == ST_ROW_HOLD || state_reg == ST_COL);
            // strobe and enable never low together: read and write are separate states
            we_n  <= !(state_reg == ST_WE_LOW);
            oe_n  <= !(state_reg == ST_RD_WAIT || state_reg == ST_RD_DATA);
            dq_oe <= (state_reg == ST_WE_LOW || state_reg == ST_WE_HOLD);
            dq_out <= req_reg.data;
        end
    end

    // ------------------------------------------------------------------
    // user status
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy      <= 1'b1;
            done      <= 1'b0;
            rd_data   <= '0;
            dev_ready <= 1'b0;
        end else begin
            busy      <= !(state_reg == ST_IDLE) || start || reset_req;
            done      <= (state_reg == ST_RD_DATA) || (state_reg == ST_WE_HIGH && cnt_zero);
            dev_ready <= rb_sync_reg;
            if (state_reg == ST_RD_DATA)
                rd_data <= dq_sync_reg;
        end
    end

    // ------------------------------------------------------------------
    // pulse-length counters for the timing assertions
    // ------------------------------------------------------------------
    logic [7:0] rp_low_cnt_reg, rp_high_cnt_reg, we_low_cnt_reg, we_high_cnt_reg;

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction : sat_inc

    // saturating level counts; 8 bits reach past every minimum checked below
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rp_low_cnt_reg  <= 8'h00;
            rp_high_cnt_reg <= 8'h00;
            we_low_cnt_reg  <= 8'h00;
            we_high_cnt_reg <= 8'hff;
        end else begin
            rp_low_cnt_reg  <= reset_power_n ? 8'h00 : sat_inc(rp_low_cnt_reg);
            rp_high_cnt_reg <= reset_power_n ? sat_inc(rp_high_cnt_reg) : 8'h00;
            we_low_cnt_reg  <= we_n ? 8'h00 : sat_inc(we_low_cnt_reg);
            we_high_cnt_reg <= we_n ? sat_inc(we_high_cnt_reg) : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_no_oe_we_low: assert property (@(posedge clock) disable iff (rst)
        !(!oe_n && !we_n)) else $error("enable and strobe low together");
    a_write_oe_high: assert property (@(posedge clock) disable iff (rst)
        !we_n |-> (oe_n && dq_oe)) else $error("enable low or data undriven during write");
    a_reset_low_len: assert property (@(posedge clock) disable iff (rst)
        $rose(reset_power_n) |-> (rp_low_cnt_reg >= RST_LOW_CYC)) else $error("reset pulse short");
    a_we_low_len: assert property (@(posedge clock) disable iff (rst)
        $rose(we_n) |-> (we_low_cnt_reg >= WE_LOW_CYC)) else $error("strobe low short");
    a_we_high_len: assert property (@(posedge clock) disable iff (rst)
        $fell(we_n) |-> (we_high_cnt_reg >= WE_HIGH_CYC)) else $error("strobe high short");
    a_read_recover: assert property (@(posedge clock) disable iff (rst)
        $fell(oe_n) |-> (we_high_cnt_reg >= WRITE_RECOVER_CYC)) else $error("read too soon after write");
    a_recover_we: assert property (@(posedge clock) disable iff (rst)
        $fell(we_n) |-> (rp_high_cnt_reg >= RST_RECOVER_CYC)) else $error("strobe too soon");
    a_recover_row: assert property (@(posedge clock) disable iff (rst)
        $fell(row_col) |-> (rp_high_cnt_reg >= RST_RECOVER_CYC)) else $error("row strobe too soon");
    a_data_drive: assert property (@(posedge clock) disable iff (rst)
        !oe_n |-> !dq_oe) else $error("host drives data during read");
    a_wr_done: assert property (@(posedge clock) disable iff (rst)
        $rose(we_n) |-> ##[30:45] done) else $error("write did not finish");

endmodule : prog_port_host

// file: verif/prog_port_dev.sv
// behavioural flash device at the far side of the programming port
// assumes the bench resolves the data bus and hands the resolved value in
`timescale 1ns/10ps
module prog_port_dev
    import prog_port_pkg::*;
#(
    parameter int BUSY_CYC  = 200,  // shortened erase/program time
    parameter int ABORT_CYC = 60,   // shortened abort time
    parameter int ACCESS_CYC = READ_ACCESS_CYC  // row_col high to valid data
)
(
    // pins
    input  wire logic              clock,
    input  wire logic              reset_power_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic              row_col,
    input  wire logic [ROW_W-1:0]  addr,
    input  wire logic [DATA_W-1:0] bus,
    input  wire logic              supply_locked,  // supply at or below program_supply_lockout_level
    output logic [DATA_W-1:0]      dev_q,
    output logic                   dev_drive,
    output logic                   ready_busy_n,
    // latched values for the bench
    output logic [ROW_W-1:0]       row_lat,
    output logic [COL_W-1:0]       col_lat,
    output logic [DATA_W-1:0]      data_lat
);
    logic wr_tog = 1'b0;
    logic tog_q  = 1'b0;
    int   busy_cnt = 0;
    int   acc_cnt  = 0;
    initial row_lat = 11'h000;
    initial col_lat = 9'h000;
    initial data_lat = 8'h00;
    // ------------------------------------------------------------------
    // address and command capture
    // ------------------------------------------------------------------
    always @(negedge row_col) row_lat = addr;
    always @(posedge row_col) col_lat = addr[COL_W-1:0];
    // any command byte is taken; the command set is not decoded here
    always @(posedge we_n) if (reset_power_n && oe_n) begin
        data_lat = bus;
        if (!supply_locked) wr_tog = ~wr_tog;
    end
    // busy starts only after the strobe rises; reset aborts a busy part
    always @(posedge clock) begin
        if (!reset_power_n && busy_cnt > ABORT_CYC) busy_cnt <= ABORT_CYC;
        else if (wr_tog != tog_q) busy_cnt <= BUSY_CYC;
        else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
        tog_q <= wr_tog;
    end
    assign ready_busy_n = (busy_cnt == 0);
    assign dev_drive = reset_power_n && !oe_n && we_n;
    // data is right only once the access time from row_col rising has run; before that it is inverted
    always @(posedge clock) acc_cnt <= row_col ? acc_cnt + 1 : 0;
    assign dev_q = (acc_cnt >= ACCESS_CYC) ? (row_lat[7:0] ^ col_lat[7:0]) : ~(row_lat[7:0] ^ col_lat[7:0]);
endmodule : prog_port_dev

// file: verif/muxed_address_programming_port_test.sv
// self-checking bench for the programming port host controller
// assumes the device model and a resolved data bus
`timescale 1ns/10ps
module muxed_address_programming_port_test;
    import prog_port_pkg::*;
    logic clock = 0, rst = 1, start = 0, reset_req = 0, supply_locked = 0;
    req_t req = '0;
    logic busy, done, dev_ready, reset_power_n, oe_n, we_n, row_col, dq_oe, dev_drive, ready_busy_n;
    logic [DATA_W-1:0] rd_data, dq_out, dq_in, dev_q, data_lat;
    logic [ROW_W-1:0] addr, row_lat;
    logic [COL_W-1:0] col_lat;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    int rec_cnt = 0, lo_cnt = 0, we_lo = 0, we_hi = 999, since_we = 999;
    logic rc_q = 1, we_q = 1, oe_q = 1, rp_q = 0, rst_pend = 1;
    // floating bus shows a changing pattern so a stale value never passes
    assign dq_in = dq_oe ? dq_out : (dev_drive ? dev_q : cyc[7:0] ^ 8'h5a);
    initial forever #2 clock = ~clock;
    prog_port_host dut_u (.clock(clock), .rst(rst), .start(start), .req(req), .reset_req(reset_req),
        .busy(busy), .done(done), .rd_data(rd_data), .dev_ready(dev_ready), .reset_power_n(reset_power_n),
        .oe_n(oe_n), .we_n(we_n), .row_col(row_col), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .ready_busy_n(ready_busy_n));
    prog_port_dev dev_u (.clock(clock), .reset_power_n(reset_power_n), .oe_n(oe_n), .we_n(we_n),
        .row_col(row_col), .addr(addr), .bus(dq_in), .supply_locked(supply_locked), .dev_q(dev_q), .dev_drive(dev_drive),
        .ready_busy_n(ready_busy_n), .row_lat(row_lat), .col_lat(col_lat), .data_lat(data_lat));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------------
    // pin timing monitor
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        // recovery counts from the later of reset and ready/busy rising after the last reset; busy after a command write does not restart it
        rec_cnt <= (!reset_power_n || (rst_pend && !ready_busy_n)) ? 0 : rec_cnt + 1;
        rst_pend <= !reset_power_n || (rst_pend && row_col);
        lo_cnt <= reset_power_n ? 0 : lo_cnt + 1;
        we_lo <= we_n ? 0 : we_lo + 1;
        we_hi <= we_n ? we_hi + 1 : 0;
        since_we <= (we_n && !we_q) ? 1 : since_we + 1;
        if (!rst) begin
            if (reset_power_n && !rp_q) chk("reset_low", 1, lo_cnt >= RST_LOW_CYC);
            if (!row_col && rc_q) chk("recover_row", 1, rec_cnt >= RST_RECOVER_CYC);
            if (!we_n && we_q) chk("recover_we", 1, rec_cnt >= RST_RECOVER_CYC && we_hi >= WE_HIGH_CYC);
            if (we_n && !we_q) chk("we_low", 1, we_lo >= WE_LOW_CYC);
            if (!oe_n && oe_q) chk("write_recover", 1, since_we >= WRITE_RECOVER_CYC);
            if (!we_n) chk("write_pins", 2'b11, {oe_n, dq_oe});
        end
        rc_q <= row_col;
        we_q <= we_n;
        oe_q <= oe_n;
        rp_q <= reset_power_n;
    end
    task automatic wait_sig(input int which, input int lim);
        int n;
        for (n = 0; n < lim && (which ? busy !== 1'b0 : done !== 1'b1); n++) @(negedge clock);
        if (n >= lim) begin
            chk("timeout", 0, 1);
            end_sim();
        end
    endtask : wait_sig
    task automatic access(input logic wr, input logic [10:0] r, input logic [8:0] c, input logic [7:0] d);
        wait_sig(1, 3000);
        req = '{write: wr, row: r, col: c, data: d};
        start = 1;
        @(negedge clock);
        start = 0;
        @(negedge clock);
        wait_sig(0, 1000);
    endtask : access
    task automatic t_write(input logic [10:0] r, input logic [8:0] c, input logic [7:0] d);
        access(1, r, c, d);
        chk("row", r, row_lat);
        chk("col", c, col_lat);
        chk("cmd", d, data_lat);
    endtask : t_write
    task automatic t_read(input logic [10:0] r, input logic [8:0] c);
        access(0, r, c, 8'h00);
        chk("rd_data", r[7:0] ^ c[7:0], rd_data);
    endtask : t_read
    task automatic t_reset_busy;
        t_write(11'h123, 9'h0a5, 8'h20);
        repeat (4) @(negedge clock);
        chk("dev_ready", 0, dev_ready);
        wait_sig(1, 100);
        reset_req = 1;
        @(negedge clock);
        reset_req = 0;
        @(negedge clock);
        wait_sig(1, 3000);
        chk("ready_after", 1, ready_busy_n);
        t_read(11'h0f0, 9'h10f);
    endtask : t_reset_busy
    task automatic t_lockout;
        supply_locked = 1;
        access(1, 11'h0aa, 9'h055, 8'h40);
        repeat (8) @(negedge clock);
        chk("locked_ready", 1, dev_ready);
        t_read(11'h0aa, 9'h055);
        supply_locked = 0;
    endtask : t_lockout
    initial begin
        repeat (2) @(negedge clock);
        chk("rst_pins", 6'b011101, {reset_power_n, oe_n, we_n, row_col, dq_oe, busy});
        repeat (4) @(negedge clock);
        rst = 0;
        t_write(11'h7ff, 9'h1ff, 8'hff);
        t_read(11'h7ff, 9'h1ff);
        t_write(11'h000, 9'h000, 8'h00);
        t_read(11'h5a5, 9'h0c3);
        t_reset_busy();
        t_lockout();
        end_sim();
    end
endmodule : muxed_address_programming_port_test
